// file: rtl/adc_serial_cfg.svh
`ifndef ADC_SERIAL_CFG_SVH
`define ADC_SERIAL_CFG_SVH

// clock and timing
`define CLK_MHZ          40
`define POWERUP_NS       10000
`define POWERUP_CYC      ((`POWERUP_NS * `CLK_MHZ) / 1000)
`define INT_CONV_MAX_NS  7500
`define INT_SLOW_NS      4444
`define RES_BITS         12
`define INT_FAST_CYC     ((`INT_CONV_MAX_NS * `CLK_MHZ) / (1000 * `RES_BITS))
`define INT_SLOW_CYC     ((`INT_SLOW_NS * `CLK_MHZ) / 1000)

// control byte, result and tick framing
`define CTRL_LAST        4'h8
`define TRACK_FROM       4'h5
`define DECODE_AT        4'h6
`define REOPEN_BITS      5'h05
`define LAST_BIT_OUT     5'h0B
`define LAST_TICK        4'hB

// control byte fields
`define BIT_SEL_HI       6
`define BIT_SEL_LO       4
`define BIT_UNI          3
`define BIT_SGL          2
`define BIT_PD_HI        1
`define BIT_PD_LO        0
`define PD_EXT           2'h3
`define PD_INT           2'h2
`define PD_OFF           2'h0

// result coding and queue depth
`define BIP_FLIP         12'h800
`define TRAIL_ZEROS      4'h0
`define RESULT_DEPTH     8

`endif

// file: rtl/adc_serial_pkg.sv
`default_nettype none

package adc_serial_pkg;

  typedef enum logic [4:0] {
    S_PWRUP = 5'h01,
    S_IDLE  = 5'h02,
    S_EXT   = 5'h04,
    S_INT   = 5'h08,
    S_OFF   = 5'h10
  } conv_state_t;

  typedef struct packed {
    logic       hard_shutdown_n_open;
    logic       hsd_n;
    logic       din;
    logic       sclk;
    logic       cs_n;
  } pins_t;

  typedef struct packed {
    logic [2:0]  chan;
    logic        single;
    logic        unipolar;
    logic [11:0] code;
  } result_t;

  typedef struct packed {
    pins_t       m1;
    pins_t       m2;
    logic        sclk_p;
    logic        cs_p;
    conv_state_t conv;
    logic [8:0]  pwr_cnt;
    logic [3:0]  ctrl_cnt;
    logic [7:0]  ctrl_sr;
    logic [7:0]  cmd;
    logic        ext_mode;
    logic        soft_pd;
    logic        cs_toggled;
    logic [7:0]  div_cnt;
    logic [3:0]  tick_cnt;
    logic [4:0]  bits_out;
    logic [15:0] out_sr;
    logic [11:0] result;
    logic        push;
    logic        dout;
    logic        dout_oe;
    logic        strobe;
    logic        strobe_oe;
    logic        track;
    logic [7:0]  pos;
    logic [8:0]  neg;
    logic        pd_out;
  } core_t;

endpackage

`default_nettype wire

// file: rtl/result_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module result_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               cnt;
    logic                        room;
    logic                        valid;
    logic [WIDTH-1:0]            head;
  } fifo_t;

  fifo_t q;
  fifo_t d;
  logic  push;
  logic  pop;

  always_comb begin
    d    = q;
    push = in_valid & q.room;
    pop  = q.valid & out_ready;
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr        = AW'(q.wr + 1'b1);
    end
    if (pop) begin
      d.rd = AW'(q.rd + 1'b1);
    end
    d.cnt   = CW'(q.cnt + CW'(push) - CW'(pop));
    d.room  = (d.cnt != CW'(DEPTH));
    d.valid = (d.cnt != '0);
    // head register shows the next word; bypass when it is being written now
    d.head  = (push && (q.wr == d.rd)) ? in_data : q.mem[d.rd];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q      <= '0;
      q.room <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign in_ready  = q.room;
  assign out_valid = q.valid;
  assign out_data  = q.head;

endmodule

`default_nettype wire

// file: rtl/adc_serial_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_serial_cfg.svh"

module adc_serial_ctrl #(
  parameter int DEPTH = `RESULT_DEPTH
) (
  input  wire logic                      CLK,
  input  wire logic                      RESETN,
  input  wire logic                      CS_N,
  input  wire logic                      SCLK,
  input  wire logic                      DIN,
  input  wire logic                      HARD_SHUTDOWN_N,
  input  wire logic                      HARD_SHUTDOWN_N_OPEN,
  input  wire logic [11:0]               ANALOG_CODE,
  output var  logic                      DOUT,
  output var  logic                      DOUT_OE,
  output var  logic                      CONVERSION_STROBE,
  output var  logic                      STROBE_OE,
  output var  logic                      TRACK_HOLD,
  output var  logic [7:0]                POS_SEL,
  output var  logic [8:0]                NEG_SEL,
  output var  logic                      POWERED_DOWN,
  output var  logic                      RESULT_VALID,
  input  wire logic                      RESULT_READY,
  output var  adc_serial_pkg::result_t   RESULT_WORD
);
  adc_serial_pkg::core_t   q;
  adc_serial_pkg::core_t   d;
  adc_serial_pkg::result_t push_word;
  logic        rise;
  logic        fall;
  logic        cs_hi;
  logic        cs_fell;
  logic        go;
  logic        start;
  logic        tick;
  logic        fifo_room;
  logic        new_ext;
  logic [7:0]  reload;
  logic [7:0]  b;
  logic [11:0] coded;

  function automatic logic [16:0] chan_mux(input logic [2:0] sel, input logic sgl);
    logic [7:0] pos;
    logic [8:0] neg;
    pos = '0;
    neg = '0;
    if (sgl) begin
      pos[{sel[1:0], sel[2]}] = 1'b1;
      neg[8]                  = 1'b1;
    end else begin
      pos[{sel[1:0], sel[2]}]  = 1'b1;
      neg[{sel[1:0], ~sel[2]}] = 1'b1;
    end
    return {neg, pos};
  endfunction

  always_comb begin
    d        = q;
    d.m1     = {HARD_SHUTDOWN_N_OPEN, HARD_SHUTDOWN_N, DIN, SCLK, CS_N};
    d.m2     = q.m1;
    d.sclk_p = q.m2.sclk;
    d.cs_p   = q.m2.cs_n;
    d.push   = 1'b0;
    cs_hi    = q.m2.cs_n;
    cs_fell  = q.cs_p & ~cs_hi;
    rise     = q.m2.sclk & ~q.sclk_p;
    fall     = ~q.m2.sclk & q.sclk_p;
    go       = fall & ~cs_hi & (q.ctrl_cnt == `CTRL_LAST) & fifo_room & q.m2.hsd_n;
    start    = rise & ~cs_hi & q.m2.din & (q.ctrl_cnt == 4'h0)
             & ((q.conv == adc_serial_pkg::S_IDLE)
             | ((q.conv == adc_serial_pkg::S_EXT) & (q.bits_out >= `REOPEN_BITS))
             | ((q.conv == adc_serial_pkg::S_INT) & q.cs_toggled));
    tick     = (q.conv == adc_serial_pkg::S_INT) & (q.div_cnt == 8'h00);
    reload   = q.m2.hard_shutdown_n_open ? 8'(`INT_FAST_CYC - 1) : 8'(`INT_SLOW_CYC - 1);
    coded    = q.ctrl_sr[`BIT_UNI] ? ANALOG_CODE : (ANALOG_CODE ^ `BIP_FLIP);
    new_ext  = (q.ctrl_sr[`BIT_PD_HI:`BIT_PD_LO] == `PD_EXT)
             | ((q.ctrl_sr[`BIT_PD_HI:`BIT_PD_LO] != `PD_INT) & q.ext_mode);

    // command receiver: blocked while select is high
    if (cs_hi) begin
      d.ctrl_cnt = 4'h0;
    end else if (rise && (start || (q.ctrl_cnt != 4'h0 && q.ctrl_cnt != `CTRL_LAST))) begin
      d.ctrl_sr  = {q.ctrl_sr[6:0], q.m2.din};
      d.ctrl_cnt = 4'(q.ctrl_cnt + 1'b1);
    end
    b = {d.ctrl_sr[5:0], 2'h0};
    if (rise && d.ctrl_cnt == `DECODE_AT) begin
      {d.neg, d.pos} = chan_mux(b[`BIT_SEL_HI:`BIT_SEL_LO], b[`BIT_SGL]);
    end
    d.track = (d.ctrl_cnt >= `TRACK_FROM);
    if (start) begin
      d.soft_pd = 1'b0;
      if (q.conv == adc_serial_pkg::S_INT) begin
        d.conv = adc_serial_pkg::S_IDLE;
      end
    end

    // select edges
    if (cs_hi && q.conv == adc_serial_pkg::S_INT) begin
      d.cs_toggled = 1'b1;
    end
    if (cs_hi && q.conv == adc_serial_pkg::S_EXT) begin
      d.conv = adc_serial_pkg::S_IDLE;
    end
    if (cs_fell && q.ext_mode) begin
      d.strobe = 1'b0;
    end

    // result shifter
    if (fall && !cs_hi) begin
      d.dout   = q.out_sr[15];
      d.out_sr = {q.out_sr[14:0], 1'b0};
      if (q.conv == adc_serial_pkg::S_EXT) begin
        d.strobe   = 1'b0;
        d.bits_out = 5'(q.bits_out + 1'b1);
        if (q.bits_out == `LAST_BIT_OUT) begin
          d.conv = adc_serial_pkg::S_IDLE;
          d.push = 1'b1;
        end
      end
    end

    // internal conversion clock
    if (q.conv == adc_serial_pkg::S_INT) begin
      if (tick) begin
        d.div_cnt  = reload;
        d.tick_cnt = 4'(q.tick_cnt + 1'b1);
        if (q.tick_cnt == `LAST_TICK) begin
          d.conv   = adc_serial_pkg::S_IDLE;
          d.strobe = 1'b1;
          d.out_sr = {q.result, `TRAIL_ZEROS};
          d.push   = 1'b1;
        end
      end else begin
        d.div_cnt = 8'(q.div_cnt - 1'b1);
      end
    end

    // conversion launch on the falling edge after the eighth bit
    if (go) begin
      d.cmd        = q.ctrl_sr;
      d.ctrl_cnt   = 4'h0;
      d.track      = 1'b0;
      d.cs_toggled = 1'b0;
      d.result     = coded;
      d.ext_mode   = new_ext;
      d.soft_pd    = (q.ctrl_sr[`BIT_PD_HI:`BIT_PD_LO] == `PD_OFF);
      if (new_ext) begin
        d.conv     = adc_serial_pkg::S_EXT;
        d.bits_out = 5'h00;
        d.strobe   = 1'b1;
        d.dout     = 1'b0;
        d.out_sr   = {coded, `TRAIL_ZEROS};
      end else begin
        d.conv     = adc_serial_pkg::S_INT;
        d.strobe   = 1'b0;
        d.div_cnt  = reload;
        d.tick_cnt = 4'h0;
      end
    end

    if (q.conv == adc_serial_pkg::S_PWRUP) begin
      if (q.pwr_cnt == 9'(`POWERUP_CYC - 1)) begin
        d.conv = adc_serial_pkg::S_IDLE;
      end else begin
        d.pwr_cnt = 9'(q.pwr_cnt + 1'b1);
      end
    end

    if (!q.m2.hsd_n) begin
      d.conv     = adc_serial_pkg::S_OFF;
      d.ctrl_cnt = 4'h0;
      d.track    = 1'b0;
      d.push     = 1'b0;
    end else if (q.conv == adc_serial_pkg::S_OFF) begin
      d.conv = adc_serial_pkg::S_IDLE;
    end

    d.dout_oe   = ~cs_hi;
    d.strobe_oe = ~(cs_hi & d.ext_mode);
    d.pd_out    = (d.conv == adc_serial_pkg::S_OFF) | (d.soft_pd & (d.conv == adc_serial_pkg::S_IDLE));
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      q         <= '0;
      q.m1      <= 5'h09;
      q.m2      <= 5'h09;
      q.cs_p    <= 1'b1;
      q.conv    <= adc_serial_pkg::S_PWRUP;
      q.strobe  <= 1'b1;
      q.strobe_oe <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign push_word = '{chan: q.cmd[`BIT_SEL_HI:`BIT_SEL_LO], single: q.cmd[`BIT_SGL],
                       unipolar: q.cmd[`BIT_UNI], code: q.result};

  // full queue holds off new launches
  result_fifo #(
    .WIDTH ($bits(adc_serial_pkg::result_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .resetn    (RESETN),
    .in_valid  (q.push),
    .in_ready  (fifo_room),
    .in_data   (push_word),
    .out_valid (RESULT_VALID),
    .out_ready (RESULT_READY),
    .out_data  (RESULT_WORD)
  );

  assign DOUT              = q.dout;
  assign DOUT_OE           = q.dout_oe;
  assign CONVERSION_STROBE = q.strobe;
  assign STROBE_OE         = q.strobe_oe;
  assign TRACK_HOLD        = q.track;
  assign POS_SEL           = q.pos;
  assign NEG_SEL           = q.neg;
  assign POWERED_DOWN      = q.pd_out;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  property p_sgl_decode;
    go && q.ctrl_sr[2] && q.ctrl_sr[6:4] == 3'h4 |-> POS_SEL == 8'h02 && NEG_SEL == 9'h100;
  endproperty
  a_sgl_decode: assert property (p_sgl_decode) else $error("single-ended decode wrong");

  property p_dif_decode;
    go && !q.ctrl_sr[2] && q.ctrl_sr[6:4] == 3'h5 |-> POS_SEL == 8'h08 && NEG_SEL == 9'h004;
  endproperty
  a_dif_decode: assert property (p_dif_decode) else $error("differential decode wrong");

  property p_bipolar;
    go && !q.ctrl_sr[3] |=> q.result == ($past(ANALOG_CODE) ^ 12'h800);
  endproperty
  a_bipolar: assert property (p_bipolar) else $error("bipolar coding wrong");

  property p_ext_pulse;
    go && q.ctrl_sr[1:0] == 2'h3 |=> CONVERSION_STROBE && q.conv == adc_serial_pkg::S_EXT && !DOUT;
  endproperty
  a_ext_pulse: assert property (p_ext_pulse) else $error("external strobe not raised");

  property p_ext_shift;
    fall && !cs_hi && q.m2.hsd_n && q.conv == adc_serial_pkg::S_EXT && !go
      |=> !CONVERSION_STROBE && DOUT == $past(q.out_sr[15]);
  endproperty
  a_ext_shift: assert property (p_ext_shift) else $error("external shift wrong");

  property p_ext_float;
    cs_hi && q.ext_mode && !go |=> !DOUT_OE && !STROBE_OE;
  endproperty
  a_ext_float: assert property (p_ext_float) else $error("outputs not floated");

  property p_int_driven;
    cs_hi && !q.ext_mode |=> STROBE_OE && !DOUT_OE;
  endproperty
  a_int_driven: assert property (p_int_driven) else $error("strobe floated in internal mode");

  property p_int_done;
    tick && q.tick_cnt == 4'hB && q.m2.hsd_n && !start && !go
      |=> CONVERSION_STROBE && q.out_sr[15:4] == $past(q.result);
  endproperty
  a_int_done: assert property (p_int_done) else $error("internal result not loaded");

  property p_powerup;
    q.conv == adc_serial_pkg::S_PWRUP |-> CONVERSION_STROBE && !q.ext_mode && q.ctrl_cnt == 4'h0;
  endproperty
  a_powerup: assert property (p_powerup) else $error("power-up state wrong");

  property p_hard_off;
    !q.m2.hsd_n |=> q.conv == adc_serial_pkg::S_OFF && POWERED_DOWN;
  endproperty
  a_hard_off: assert property (p_hard_off) else $error("shutdown not forced");

  c_ext_done: cover property (q.push && q.ext_mode);
  c_int_done: cover property (q.push && !q.ext_mode);
  c_overlap:  cover property (start && q.conv == adc_serial_pkg::S_EXT);
  c_full:     cover property (!fifo_room);

endmodule

`default_nettype wire

// file: dv/host_link_model.sv
`timescale 1ns/10ps
`default_nettype none

module host_link_model (
  output var  logic cs_n,
  output var  logic sclk,
  output var  logic din,
  input  wire logic dout
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end

  // select changes only with the link clock parked low
  task automatic sel(input logic lvl);
    #100 cs_n = lvl;
  endtask

  // mode 0 byte: data set in low phase, read just before the fall
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      din = tx[i];
      #100 sclk = 1'b1;
      #99 rx[i] = dout;
      #1 sclk = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// file: dv/serial_adc_control_interface_test.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end

module serial_adc_control_interface_test;
  logic                    CLK = 1'b0;
  logic                    RESETN;
  logic                    CS_N;
  logic                    SCLK;
  logic                    DIN;
  logic                    HARD_SHUTDOWN_N;
  logic                    HARD_SHUTDOWN_N_OPEN;
  logic [11:0]             ANALOG_CODE;
  logic                    DOUT;
  logic                    DOUT_OE;
  logic                    CONVERSION_STROBE;
  logic                    STROBE_OE;
  logic                    TRACK_HOLD;
  logic [7:0]              POS_SEL;
  logic [8:0]              NEG_SEL;
  logic                    POWERED_DOWN;
  logic                    RESULT_VALID;
  logic                    RESULT_READY;
  adc_serial_pkg::result_t RESULT_WORD;
  adc_serial_pkg::result_t exp_q[$];
  adc_serial_pkg::result_t seen;
  logic                    dout_pin;
  logic                    stall = 1'b1;
  logic [7:0]              r;
  logic [7:0]              r2;
  int                      n_fail = 0;
  int                      checks = 0;
  int                      n;

  always #12.5 CLK = ~CLK;

  // a released output line shows the inverse of its last value
  assign dout_pin = DOUT_OE ? DOUT : ~DOUT;

  host_link_model i_host (
    .cs_n (CS_N),
    .sclk (SCLK),
    .din  (DIN),
    .dout (dout_pin)
  );

  adc_serial_ctrl i_dut (
    .CLK               (CLK),
    .RESETN            (RESETN),
    .CS_N              (CS_N),
    .SCLK              (SCLK),
    .DIN               (DIN),
    .HARD_SHUTDOWN_N   (HARD_SHUTDOWN_N),
    .HARD_SHUTDOWN_N_OPEN         (HARD_SHUTDOWN_N_OPEN),
    .ANALOG_CODE       (ANALOG_CODE),
    .DOUT              (DOUT),
    .DOUT_OE           (DOUT_OE),
    .CONVERSION_STROBE (CONVERSION_STROBE),
    .STROBE_OE         (STROBE_OE),
    .TRACK_HOLD        (TRACK_HOLD),
    .POS_SEL           (POS_SEL),
    .NEG_SEL           (NEG_SEL),
    .POWERED_DOWN      (POWERED_DOWN),
    .RESULT_VALID      (RESULT_VALID),
    .RESULT_READY      (RESULT_READY),
    .RESULT_WORD       (RESULT_WORD)
  );

  task automatic wrap_up;
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(negedge CLK) begin
    RESULT_READY <= stall ? 1'b0 : 1'($urandom);
  end

  always @(posedge CLK) begin
    if (RESULT_VALID === 1'b1 && RESULT_READY === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK("extra_word", 1'b0, 1'b1)
      end else begin
        seen = exp_q.pop_front();
        `CHK("result_word", seen, RESULT_WORD)
      end
    end
  end

  // lim zero: external mode; otherwise bound on the internal busy time
  task automatic conv(input logic [7:0] ctl, input bit push, input int lim);
    logic [7:0]  r1;
    logic [7:0]  r2;
    logic [11:0] code;
    int          k;
    @(negedge CLK);
    ANALOG_CODE = 12'($urandom);
    code = ctl[3] ? ANALOG_CODE : ANALOG_CODE ^ 12'h800;
    i_host.sel(1'b0);
    i_host.xfer(ctl, r1);
    if (push) exp_q.push_back('{ctl[6:4], ctl[2], ctl[3], code});
    repeat (6) @(negedge CLK);
    `CHK("pos_sel", 8'h01 << {ctl[5:4], ctl[6]}, POS_SEL)
    `CHK("neg_sel", ctl[2] ? 9'h100 : 9'h001 << {ctl[5:4], ~ctl[6]}, NEG_SEL)
    `CHK("track", !push, TRACK_HOLD)
    if (push) `CHK("strobe", lim == 0, CONVERSION_STROBE)
    if (lim == 0) begin
      i_host.xfer(8'h00, r1);
      i_host.xfer(8'h00, r2);
      i_host.sel(1'b1);
    end else begin
      i_host.sel(1'b1);
      repeat (6) @(negedge CLK);
      `CHK("oe_int", 2'b10, {STROBE_OE, DOUT_OE})
      for (k = 0; k < lim && CONVERSION_STROBE !== 1'b1; k++) @(negedge CLK);
      if (k == lim) begin
        n_fail++;
        wrap_up();
      end
      i_host.sel(1'b0);
      i_host.xfer(8'h00, r1);
      i_host.xfer(8'h00, r2);
      i_host.sel(1'b1);
      r1[7] = 1'b0;
    end
    repeat (6) @(negedge CLK);
    if (push) `CHK("serial_data", {1'b0, code, 3'b000}, {r1, r2})
    if (lim == 0) `CHK("oe_ext", 2'b00, {STROBE_OE, DOUT_OE})
  endtask

  initial begin
    #2000000;
    n_fail++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h956B));
    RESETN          = 1'b0;
    HARD_SHUTDOWN_N = 1'b1;
    HARD_SHUTDOWN_N_OPEN       = 1'($urandom);
    ANALOG_CODE     = 12'($urandom);
    repeat (8) @(negedge CLK);
    RESETN = 1'b1;
    repeat (2) @(negedge CLK);
    `CHK("power_up", 4'b1100, {CONVERSION_STROBE, STROBE_OE, DOUT_OE, POWERED_DOWN})
    repeat (420) @(negedge CLK);
    // fifo fills; the ninth launch is refused
    for (int k = 0; k < 9; k++) conv({1'b1, 3'(k), 2'b11, 2'b11}, k < 8, 0);
    @(negedge CLK);
    stall = 1'b0;
    for (int k = 0; k < 16; k++) conv({1'b1, 3'(k), 1'($urandom), k[3], 2'b11}, 1, 0);
    HARD_SHUTDOWN_N_OPEN = 1'b1;
    conv(8'b1101_1110, 1, 320);
    @(negedge CLK);
    HARD_SHUTDOWN_N_OPEN = 1'b0;
    conv(8'b1010_0010, 1, 2200);
    @(negedge CLK);
    HARD_SHUTDOWN_N_OPEN = 1'b1;
    // abort by select toggle after part of the result
    i_host.sel(1'b0);
    i_host.xfer(8'hFF, r);
    i_host.xfer(8'h00, r);
    i_host.sel(1'b1);
    conv(8'b1011_0111, 1, 0);
    conv(8'b1001_1100, 1, 0);
    repeat (6) @(negedge CLK);
    `CHK("soft_down", 1'b1, POWERED_DOWN)
    conv(8'b1110_0111, 1, 0);
    `CHK("woken", 1'b0, POWERED_DOWN)
    // next control byte rides on the tail of a running result
    ANALOG_CODE = 12'($urandom);
    repeat (2) exp_q.push_back('{3'h7, 1'b1, 1'b1, ANALOG_CODE});
    i_host.sel(1'b0);
    i_host.xfer(8'hFF, r);
    i_host.xfer(8'h00, r);
    i_host.xfer(8'hFF, r2);
    `CHK("overlap_old", {1'b0, ANALOG_CODE, 3'b000}, {r, r2})
    i_host.xfer(8'h00, r);
    i_host.xfer(8'h00, r2);
    i_host.sel(1'b1);
    `CHK("overlap_new", {1'b0, ANALOG_CODE, 3'b000}, {r, r2})
    repeat (6) @(negedge CLK);
    i_host.sel(1'b0);
    i_host.xfer(8'b1100_1110, r);
    @(negedge CLK);
    HARD_SHUTDOWN_N = 1'b0;
    repeat (8) @(negedge CLK);
    `CHK("hard_down", 1'b1, POWERED_DOWN)
    HARD_SHUTDOWN_N = 1'b1;
    i_host.sel(1'b1);
    repeat (8) @(negedge CLK);
    conv(8'b1111_1111, 1, 0);
    for (n = 0; n < 2000 && exp_q.size() > 0; n++) @(negedge CLK);
    if (n == 2000) n_fail++;
    wrap_up();
  end
endmodule

`default_nettype wire
